// *** rtl/cpu_register_set.v ***
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "reg_set_map.vh"
module cpu_register_set
(
    input wire clock, // Core clock
    input wire rst, // Synchronous reset, high
    input wire [3:0] aluOp, // ALU operation, one cycle
    input wire [2:0] aluSrc, // Operand byte register (B..L, M, A)
    input wire [7:0] memData, // Byte used when source is memory
    input wire [2:0] incSel, // Byte register for increment/decrement
    input wire writeByte, // Load a byte register
    input wire [2:0] byteSel, // Byte register to load
    input wire [7:0] byteData, // Byte to load
    input wire writePair, // Load a 16-bit pair
    input wire [1:0] pairSel, // Pair to load or read
    input wire [15:0] pairData, // Pair value
    input wire pairInc, // Pair increment, flags untouched
    input wire pairDec, // Pair decrement, flags untouched
    input wire stackPush, // Stack push
    input wire stackPop, // Stack pop
    input wire fetchStep, // Advance fetch pointer by one
    input wire fetchLoad, // Load fetch pointer
    input wire [15:0] fetchData, // New fetch address
    input wire [3:0] regAddr, // Software register index
    input wire [7:0] regWdata, // Software write data
    input wire regWrite, // Software write strobe
    input wire regRead, // Software read strobe
    output reg [7:0] regRdata_ff, // Software read data
    output reg [7:0] workReg_ff, // Working result register
    output reg [7:0] flags_ff, // Condition indicators
    output reg [15:0] fetchPtr_ff, // Next fetch pointer
    output reg [15:0] stackPtr_ff, // Stack top pointer
    output reg [15:0] pairOut_ff, // Selected pair, one cycle after select
    output reg [15:0] memAddr_ff // Memory pointer pair
);
    reg [7:0] gen_ff [0:5];
    reg [7:0] nxt_work;
    reg [7:0] nxt_flags;
    reg [15:0] nxt_fetch;
    reg [15:0] nxt_stack;
    reg [7:0] nxt_rdata;
    reg [15:0] nxt_pairOut;
    reg [15:0] nxt_memAddr;
    reg stepOp;
    reg pairOp;
    reg [15:0] pairVal;
    reg [15:0] pairNew;
    reg [7:0] operand;
    reg [7:0] incIn;
    reg [3:0] opUsed;
    reg [7:0] opLeft;
    integer k;
    wire [7:0] aluRes;
    wire aluCarry;
    wire aluNib;
    wire aluUpdC;
    wire aluUpdF;

    // Pair value: first register is high byte
    function [15:0] pairOf;
        input [1:0] sel;
        input [7:0] b0;
        input [7:0] b1;
        input [7:0] b2;
        input [7:0] b3;
        input [7:0] b4;
        input [7:0] b5;
        input [15:0] stk;
        begin
            case (sel)
                `PAIR_ONE: pairOf = {b0, b1};
                `PAIR_TWO: pairOf = {b2, b3};
                `PAIR_MEM: pairOf = {b4, b5};
                default: pairOf = stk;
            endcase
        end
    endfunction

    // Even number of ones gives 1
    function evenParity;
        input [7:0] v;
        begin
            evenParity = ~^v;
        end
    endfunction

    // Flag byte with fixed bits forced, so results cannot touch them
    function [7:0] packFlags;
        input s;
        input z;
        input n;
        input p;
        input c;
        reg [7:0] t;
        begin
            t = 8'h00;
            t[`FLAG_SIGN] = s;
            t[`FLAG_ZERO] = z;
            t[`FLAG_NIB] = n;
            t[`FLAG_PAR] = p;
            t[`FLAG_CARRY] = c;
            packFlags = (t & ~`FLAG_FIXED_MASK) | `FLAG_FIXED_VAL;
        end
    endfunction

    function [7:0] byteOf;
        input [2:0] sel;
        input [7:0] accum;
        input [7:0] mem;
        input [7:0] b0;
        input [7:0] b1;
        input [7:0] b2;
        input [7:0] b3;
        input [7:0] b4;
        input [7:0] b5;
        begin
            case (sel)
                `SEL_B: byteOf = b0;
                `SEL_C: byteOf = b1;
                `SEL_D: byteOf = b2;
                `SEL_E: byteOf = b3;
                `SEL_H: byteOf = b4;
                `SEL_L: byteOf = b5;
                `SEL_M: byteOf = mem;
                default: byteOf = accum;
            endcase
        end
    endfunction

    // Increment and decrement share the operand path of the ALU
    function isStep;
        input [3:0] op;
        begin
            isStep = (op == `OP_INR) || (op == `OP_DCR);
        end
    endfunction

    // Software write aimed at one register index
    function swHit;
        input we;
        input [3:0] adr;
        input [3:0] idx;
        begin
            swHit = we && (adr == idx);
        end
    endfunction

    // Replace one half of a 16-bit pointer; the other half stands
    function [15:0] setByte;
        input [15:0] ptr;
        input hi;
        input [7:0] b;
        begin
            if (hi)
                setByte = {b, ptr[7:0]};
            else
                setByte = {ptr[15:8], b};
        end
    endfunction

    flag_alu u_alu
    (
        .op(opUsed),
        .opA(opLeft),
        .opB(operand),
        .carryIn(flags_ff[`FLAG_CARRY]),
        .result(aluRes),
        .carryOut(aluCarry),
        .nibbleOut(aluNib),
        .updCarry(aluUpdC),
        .updFlags(aluUpdF)
    );

    always @*
    begin
        operand = byteOf(aluSrc, workReg_ff, memData, gen_ff[0], gen_ff[1], gen_ff[2],
            gen_ff[3], gen_ff[4], gen_ff[5]);
        incIn = byteOf(incSel, workReg_ff, memData, gen_ff[0], gen_ff[1], gen_ff[2],
            gen_ff[3], gen_ff[4], gen_ff[5]);
        opUsed = aluOp;
        // One decode of the step operations feeds the operand mux and the byte file
        stepOp = isStep(aluOp);
        pairOp = writePair || pairInc || pairDec;
        opLeft = stepOp ? incIn : workReg_ff;
        pairVal = pairOf(pairSel, gen_ff[0], gen_ff[1], gen_ff[2], gen_ff[3], gen_ff[4],
            gen_ff[5], stackPtr_ff);
        pairNew = pairVal;
        if (writePair)
            pairNew = pairData;
        else if (pairInc)
            pairNew = pairVal + 16'h0001;
        else if (pairDec)
            pairNew = pairVal - 16'h0001;
    end

    // Working register: only ever a single byte
    always @*
    begin
        nxt_work = workReg_ff;
        if (aluUpdF && (aluOp != `OP_CMP) && !stepOp)
            nxt_work = aluRes;
        else if (stepOp && incSel == `SEL_A)
            nxt_work = aluRes;
        else if (writeByte && byteSel == `SEL_A)
            nxt_work = byteData;
        // Software write comes last so it beats a core update in the same cycle
        if (swHit(regWrite, regAddr, `ADR_WORK))
            nxt_work = regWdata;
    end

    always @*
    begin
        nxt_flags = flags_ff;
        if (aluUpdF)
            nxt_flags = packFlags(aluRes[7],
                aluRes == 8'h00,
                aluNib,
                evenParity(aluRes),
                aluUpdC ? aluCarry : flags_ff[`FLAG_CARRY]);
        if (swHit(regWrite, regAddr, `ADR_FLAGS))
            nxt_flags = packFlags(regWdata[7], regWdata[6], regWdata[4], regWdata[2],
                regWdata[0]);
    end

    // Stack moves by two bytes; grows downward
    always @*
    begin
        nxt_stack = stackPtr_ff;
        if (stackPush)
            nxt_stack = stackPtr_ff - `STACK_STEP;
        else if (stackPop)
            nxt_stack = stackPtr_ff + `STACK_STEP;
        else if (pairSel == `PAIR_STK && pairOp)
            nxt_stack = pairNew;
        // Halves are written one at a time; software must not rely on an atomic pair
        if (swHit(regWrite, regAddr, `ADR_STACK_LO))
            nxt_stack = setByte(stackPtr_ff, 1'b0, regWdata);
        if (swHit(regWrite, regAddr, `ADR_STACK_HI))
            nxt_stack = setByte(stackPtr_ff, 1'b1, regWdata);
    end

    always @*
    begin
        nxt_fetch = fetchPtr_ff;
        // A jump load wins over the plain step
        if (fetchLoad)
            nxt_fetch = fetchData;
        else if (fetchStep)
            nxt_fetch = fetchPtr_ff + 16'h0001;
        if (swHit(regWrite, regAddr, `ADR_FETCH_LO))
            nxt_fetch = setByte(fetchPtr_ff, 1'b0, regWdata);
        if (swHit(regWrite, regAddr, `ADR_FETCH_HI))
            nxt_fetch = setByte(fetchPtr_ff, 1'b1, regWdata);
    end

    always @*
    begin
        nxt_rdata = 8'h00;
        if (regRead)
        begin
            case (regAddr)
                `ADR_WORK: nxt_rdata = workReg_ff;
                `ADR_FLAGS: nxt_rdata = flags_ff;
                `ADR_FETCH_LO: nxt_rdata = fetchPtr_ff[7:0];
                `ADR_FETCH_HI: nxt_rdata = fetchPtr_ff[15:8];
                `ADR_STACK_LO: nxt_rdata = stackPtr_ff[7:0];
                `ADR_STACK_HI: nxt_rdata = stackPtr_ff[15:8];
                `ADR_GEN_B: nxt_rdata = gen_ff[0];
                `ADR_GEN_C: nxt_rdata = gen_ff[1];
                `ADR_GEN_D: nxt_rdata = gen_ff[2];
                `ADR_GEN_E: nxt_rdata = gen_ff[3];
                `ADR_GEN_H: nxt_rdata = gen_ff[4];
                `ADR_GEN_L: nxt_rdata = gen_ff[5];
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // Pair view lags its select by one cycle and shows the value before that edge
    always @*
    begin
        nxt_pairOut = pairVal;
        nxt_memAddr = {gen_ff[4], gen_ff[5]};
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            workReg_ff <= `RST_WORK;
            flags_ff <= `RST_FLAGS;
            fetchPtr_ff <= `RST_PTR;
            stackPtr_ff <= `RST_PTR;
        end
        else
        begin
            workReg_ff <= nxt_work;
            flags_ff <= nxt_flags;
            fetchPtr_ff <= nxt_fetch;
            stackPtr_ff <= nxt_stack;
        end
    end

    // Read data stands for one cycle only, then drops back to zero
    always @(posedge clock)
    begin
        if (rst)
        begin
            regRdata_ff <= 8'h00;
            pairOut_ff <= 16'h0000;
            memAddr_ff <= 16'h0000;
        end
        else
        begin
            regRdata_ff <= nxt_rdata;
            pairOut_ff <= nxt_pairOut;
            // Memory pointer pair drives data addressing
            memAddr_ff <= nxt_memAddr;
        end
    end

    // Byte and pair writes share the six general bytes; software write wins,
    // then increment or decrement, then byte load, then pair operation
    always @(posedge clock)
    begin
        for (k = 0; k < 6; k = k + 1)
        begin
            if (rst)
                gen_ff[k] <= 8'h00;
            else if (swHit(regWrite, regAddr, `ADR_GEN_B + k[3:0]))
                gen_ff[k] <= regWdata;
            else if (stepOp && incSel == k[2:0])
                gen_ff[k] <= aluRes;
            else if (writeByte && byteSel == k[2:0])
                gen_ff[k] <= byteData;
            else if (pairSel != `PAIR_STK && pairSel == k[2:1] && pairOp)
                gen_ff[k] <= k[0] ? pairNew[7:0] : pairNew[15:8];
        end
    end
endmodule // cpu_register_set

// *** inc/reg_set_map.vh ***
`ifndef REG_SET_MAP_VH
`define REG_SET_MAP_VH
// Software register indices (word offsets on the plain port)
`define ADR_WORK 4'h0
`define ADR_FLAGS 4'h1
`define ADR_FETCH_LO 4'h2
`define ADR_FETCH_HI 4'h3
`define ADR_STACK_LO 4'h4
`define ADR_STACK_HI 4'h5
`define ADR_GEN_B 4'h6
`define ADR_GEN_C 4'h7
`define ADR_GEN_D 4'h8
`define ADR_GEN_E 4'h9
`define ADR_GEN_H 4'ha
`define ADR_GEN_L 4'hb
// Flag field positions
`define FLAG_SIGN 7
`define FLAG_ZERO 6
`define FLAG_NIB 4
`define FLAG_PAR 2
`define FLAG_CARRY 0
// Fixed values of the bits that hold no flag (bit 5, 3, 1)
`define FLAG_FIXED_MASK 8'h2a
`define FLAG_FIXED_VAL 8'h02
// Reset values and stack step
`define RST_WORK 8'h00
`define RST_FLAGS 8'h02
`define RST_PTR 16'h0000
`define STACK_STEP 16'h0002
// Register selects of the core port (byte registers)
`define SEL_B 3'h0
`define SEL_C 3'h1
`define SEL_D 3'h2
`define SEL_E 3'h3
`define SEL_H 3'h4
`define SEL_L 3'h5
`define SEL_M 3'h6
`define SEL_A 3'h7
// Pair selects
`define PAIR_ONE 2'h0
`define PAIR_TWO 2'h1
`define PAIR_MEM 2'h2
`define PAIR_STK 2'h3
// Operations
`define OP_NONE 4'h0
`define OP_ADD 4'h1
`define OP_ADC 4'h2
`define OP_SUB 4'h3
`define OP_SBB 4'h4
`define OP_AND 4'h5
`define OP_XOR 4'h6
`define OP_OR 4'h7
`define OP_CMP 4'h8
`define OP_INR 4'h9
`define OP_DCR 4'ha
`endif

// *** rtl/flag_alu.v ***
`timescale 1ns/1ps
`include "reg_set_map.vh"
module flag_alu
(
    input wire [3:0] op, // Operation select
    input wire [7:0] opA, // Left operand
    input wire [7:0] opB, // Right operand
    input wire carryIn, // Current carry flag
    output reg [7:0] result, // Result byte
    output reg carryOut, // New carry
    output reg nibbleOut, // New nibble carry
    output reg updCarry, // Operation affects carry
    output reg updFlags // Operation affects sign, zero, parity, nibble
);
    reg [8:0] wide;
    reg [4:0] low;
    reg cin;
    always @*
    begin
        wide = 9'h000;
        low = 5'h00;
        cin = 1'b0;
        result = opA;
        carryOut = carryIn;
        nibbleOut = 1'b0;
        updCarry = 1'b0;
        updFlags = 1'b1;
        case (op)
            `OP_ADD, `OP_ADC:
            begin
                cin = (op == `OP_ADC) ? carryIn : 1'b0;
                wide = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
                low = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
                result = wide[7:0];
                carryOut = wide[8];
                nibbleOut = low[4];
                updCarry = 1'b1;
            end
            `OP_SUB, `OP_SBB, `OP_CMP:
            begin
                cin = (op == `OP_SBB) ? carryIn : 1'b0;
                wide = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
                low = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
                result = wide[7:0];
                carryOut = wide[8];
                // Nibble flag shows carry of the two's-complement add, i.e. no low borrow
                nibbleOut = ~low[4];
                updCarry = 1'b1;
            end
            `OP_AND:
            begin
                result = opA & opB;
                carryOut = 1'b0;
                nibbleOut = opA[3] | opB[3];
                updCarry = 1'b1;
            end
            `OP_XOR:
            begin
                result = opA ^ opB;
                carryOut = 1'b0;
                updCarry = 1'b1;
            end
            `OP_OR:
            begin
                result = opA | opB;
                carryOut = 1'b0;
                updCarry = 1'b1;
            end
            `OP_INR:
            begin
                result = opA + 8'h01;
                nibbleOut = (opA[3:0] == 4'hf);
            end
            `OP_DCR:
            begin
                result = opA - 8'h01;
                nibbleOut = (opA[3:0] != 4'h0);
            end
            default:
            begin
                updFlags = 1'b0;
            end
        endcase
    end
endmodule // flag_alu

// *** bench/reg_set_assertions.sv ***
`timescale 1ns/1ps
`include "reg_set_map.vh"
module reg_set_assertions
(
    input wire clock, // Core clock
    input wire rst, // Sync reset
    input wire [3:0] aluOp, // Operation
    input wire [2:0] aluSrc, // Operand select
    input wire [7:0] memData, // Memory operand
    input wire regWrite, // Software write
    input wire regRead, // Software read
    input wire [3:0] regAddr, // Software index
    input wire stackPush, // Push
    input wire fetchStep, // Fetch advance
    input wire fetchLoad, // Fetch load
    input wire [7:0] regRdata_ff, // Read data
    input wire [7:0] workReg_ff, // Working register
    input wire [7:0] flags_ff, // Flags
    input wire [15:0] fetchPtr_ff, // Fetch pointer
    input wire [15:0] stackPtr_ff // Stack pointer
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Memory operand keeps the right-hand value visible at the ports
    wire memOp = aluSrc == `SEL_M && !regWrite;
    wire resOp = memOp && aluOp >= `OP_ADD && aluOp <= `OP_OR;
    wire [8:0] sum = workReg_ff + memData;
    wire [8:0] diff = workReg_ff - memData;
    wire [4:0] nsum = workReg_ff[3:0] + memData[3:0];
    property p_fixed_bits;
        (flags_ff & 8'h2a) == 8'h02;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("spare flag bits moved");
    property p_add_res;
        aluOp == `OP_ADD && memOp |=> workReg_ff == $past(sum[7:0]) && flags_ff[0] == $past(sum[8]);
    endproperty
    a_add_res: assert property (p_add_res) else $error("add result or carry wrong");
    property p_add_nib;
        aluOp == `OP_ADD && memOp |=> flags_ff[4] == $past(nsum[4]);
    endproperty
    a_add_nib: assert property (p_add_nib) else $error("nibble carry wrong");
    property p_sub_borrow;
        aluOp == `OP_SUB && memOp |=> flags_ff[0] == $past(diff[8]);
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow wrong");
    property p_sign_zero;
        resOp |=> flags_ff[7] == workReg_ff[7] && flags_ff[6] == (workReg_ff == 8'h00);
    endproperty
    a_sign_zero: assert property (p_sign_zero) else $error("sign or zero wrong");
    property p_parity;
        resOp |=> flags_ff[2] == ~^workReg_ff;
    endproperty
    a_parity: assert property (p_parity) else $error("parity wrong");
    property p_push;
        stackPush && !regWrite |=> stackPtr_ff == $past(stackPtr_ff) - 16'h0002;
    endproperty
    a_push: assert property (p_push) else $error("push step wrong");
    property p_fetch;
        fetchStep && !fetchLoad && !regWrite |=> fetchPtr_ff == $past(fetchPtr_ff) + 16'h0001;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch step wrong");
    property p_read_once;
        regRead && regAddr == `ADR_WORK && aluOp == `OP_NONE && !regWrite
            |=> regRdata_ff == $past(workReg_ff) ##1 ($past(regRead) || regRdata_ff == 8'h00);
    endproperty
    a_read_once: assert property (p_read_once) else $error("read data timing wrong");
    c_add: cover property (aluOp == `OP_ADD && memOp ##1 flags_ff[0] && flags_ff[6]);
    c_push: cover property (stackPush);
    c_read: cover property (regRead ##1 regRdata_ff != 8'h00);
endmodule // reg_set_assertions

// *** bench/tb_cpu_register_set_and_flags.sv ***
`timescale 1ns/1ps
`include "reg_set_map.vh"
module tb_cpu_register_set_and_flags;
    reg clock = 0, rst = 1, writeByte = 0, writePair = 0, pairInc = 0, pairDec = 0;
    reg stackPush = 0, stackPop = 0, fetchStep = 0, fetchLoad = 0, regWrite = 0, regRead = 0;
    reg [3:0] aluOp = 0, regAddr = 0;
    reg [2:0] aluSrc = 0, incSel = 0, byteSel = 0;
    reg [7:0] memData = 0, byteData = 0, regWdata = 0;
    reg [1:0] pairSel = 0;
    reg [15:0] pairData = 0, fetchData = 0;
    wire [7:0] regRdata_ff, workReg_ff, flags_ff;
    wire [15:0] fetchPtr_ff, stackPtr_ff, pairOut_ff, memAddr_ff;
    integer errors = 0, n_checks = 0, seed = 32'h6a03ec4c, cyc = 0, i, v, wk = 0, fl = 2;
    integer stk = 0, fp = 0;
    integer g [0:5];
    cpu_register_set dut (.clock, .rst, .aluOp, .aluSrc, .memData, .incSel, .writeByte,
        .byteSel, .byteData, .writePair, .pairSel, .pairData, .pairInc, .pairDec, .stackPush,
        .stackPop, .fetchStep, .fetchLoad, .fetchData, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata_ff, .workReg_ff, .flags_ff, .fetchPtr_ff, .stackPtr_ff,
        .pairOut_ff, .memAddr_ff);
    initial forever #5 clock = ~clock;
    task test_done;
        begin
            $display("errors %0d checks %0d", errors, n_checks);
            if (errors == 0 && n_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    // Ceiling sits well above the roughly one thousand cycles the sequence needs
    always @(posedge clock)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            errors = errors + 1;
            test_done;
        end
    end
    task chk(input string nm, input [15:0] e, input [15:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== e)
            begin
                errors = errors + 1;
                $display("Error %s expected %h seen %h", nm, e, got);
            end
        end
    endtask
    // Strobes drop one edge later; results are looked at on the falling edge
    task fin;
        begin
            @(posedge clock);
            {aluOp, writeByte, writePair, pairInc, pairDec, stackPush, stackPop} <= '0;
            {fetchStep, fetchLoad, regWrite, regRead} <= '0;
            @(negedge clock);
        end
    endtask
    function integer mdl(input integer a);
        case (a)
            0: mdl = wk;
            1: mdl = fl;
            2: mdl = fp & 255;
            3: mdl = fp >> 8;
            4: mdl = stk & 255;
            5: mdl = stk >> 8;
            default: mdl = a < 12 ? g[a - 6] : 0;
        endcase
    endfunction
    function integer pv(input integer p);
        pv = p == 3 ? stk : g[2 * p] * 256 + g[2 * p + 1];
    endfunction
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clock);
            regAddr <= a;
            regWdata <= d;
            regWrite <= 1;
            case (a)
                0: wk = d;
                1: fl = d & 8'hd5 | 8'h02;
                2: fp = fp & 16'hff00 | d;
                3: fp = fp & 255 | d << 8;
                4: stk = stk & 16'hff00 | d;
                5: stk = stk & 255 | d << 8;
                default: if (a < 12) g[a - 6] = d;
            endcase
            fin;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge clock);
            regAddr <= a;
            regRead <= 1;
            fin;
            chk("read data", mdl(a), regRdata_ff);
        end
    endtask
    function integer fmk(input integer r, input integer n, input integer c);
        fmk = r & 128 | (r == 0) << 6 | n << 4 | !(^r) << 2 | 2 | c;
    endfunction
    task alu(input [3:0] op, input [2:0] s, input [7:0] m);
        integer a, b, r, n, c, ci;
        begin
            a = wk;
            b = s == 6 ? m : s == 7 ? wk : g[s];
            c = fl & 1;
            ci = (op == `OP_ADC || op == `OP_SBB) ? c : 0;
            if (op <= `OP_ADC)
            begin
                r = a + b + ci;
                n = (a & 15) + (b & 15) + ci > 15;
                c = r > 255;
            end
            else if (op >= `OP_AND && op <= `OP_OR)
            begin
                r = op == `OP_AND ? a & b : op == `OP_XOR ? a ^ b : a | b;
                n = op == `OP_AND ? (a | b) >> 3 & 1 : 0;
                c = 0;
            end
            else
            begin
                r = a - b - ci;
                n = (a & 15) >= (b & 15) + ci;
                c = r < 0;
            end
            r = r & 255;
            fl = fmk(r, n, c);
            if (op != `OP_CMP) wk = r;
            @(posedge clock);
            aluOp <= op;
            aluSrc <= s;
            memData <= m;
            fin;
            chk("working", wk, workReg_ff);
            chk("flags", fl, flags_ff);
        end
    endtask
    task idc(input [3:0] op, input [2:0] s);
        integer t, n;
        begin
            t = s == 7 ? wk : s == 6 ? memData : g[s];
            n = op == `OP_INR ? (t & 15) == 15 : (t & 15) != 0;
            t = (op == `OP_INR ? t + 1 : t - 1) & 255;
            if (s == 7) wk = t;
            else if (s < 6) g[s] = t;
            fl = fmk(t, n, fl & 1);
            @(posedge clock);
            aluOp <= op;
            incSel <= s;
            fin;
            chk("flags", fl, flags_ff);
            rd(s == 7 ? 0 : s + 6);
        end
    endtask
    // Kind: 0 pair load, 1 inc, 2 dec, 3 push, 4 pop, 5 fetch load, 6 fetch step
    task pr(input integer k, input [1:0] p, input [15:0] d);
        begin
            v = k == 0 ? d : k == 1 ? pv(p) + 1 : pv(p) - 1;
            if (k < 3 && p == 3) stk = v & 16'hffff;
            else if (k < 3)
            begin
                g[2 * p] = v >> 8 & 255;
                g[2 * p + 1] = v & 255;
            end
            if (k == 3) stk = (stk - 2) & 16'hffff;
            if (k == 4) stk = (stk + 2) & 16'hffff;
            if (k == 5) fp = d;
            if (k == 6) fp = (fp + 1) & 16'hffff;
            @(posedge clock);
            pairSel <= p;
            pairData <= d;
            fetchData <= d;
            {fetchStep, fetchLoad, stackPop, stackPush, pairDec, pairInc, writePair} <= 7'h01 << k;
            fin;
            @(posedge clock);
            @(negedge clock);
            chk("stack", stk, stackPtr_ff);
            chk("fetch", fp, fetchPtr_ff);
            chk("pair", pv(p), pairOut_ff);
            chk("pointer", pv(2), memAddr_ff);
        end
    endtask
    initial
    begin
        for (i = 0; i < 6; i = i + 1) g[i] = 0;
        repeat (8) @(posedge clock);
        rst <= 0;
        for (i = 0; i < 16; i = i + 1) rd(i);
        wr(`ADR_FLAGS, 8'hff);
        rd(`ADR_FLAGS);
        for (i = 0; i < 6; i = i + 1)
        begin
            v = $random(seed) & 255;
            g[i] = v;
            @(posedge clock);
            writeByte <= 1;
            byteSel <= i;
            byteData <= v;
            fin;
        end
        wr(`ADR_WORK, 8'hae);
        alu(`OP_ADD, `SEL_M, 8'h74);
        wr(`ADR_WORK, 8'ha7);
        alu(`OP_ADD, `SEL_M, 8'h59);
        wr(`ADR_WORK, 8'h03);
        alu(`OP_SUB, `SEL_M, 8'h05);
        repeat (300) alu(1 + ($random(seed) & 7), $random(seed), $random(seed));
        wr(`ADR_GEN_B, 8'hff);
        idc(`OP_INR, `SEL_B);
        wr(`ADR_WORK, 8'h01);
        idc(`OP_DCR, `SEL_A);
        repeat (20) idc(`OP_INR + ($random(seed) & 1), 3'h7 & ($random(seed) | 4));
        pr(0, 3, 16'h0002);
        pr(3, 3, 0);
        pr(4, 3, 0);
        pr(5, 0, 16'hfffe);
        pr(6, 0, 0);
        pr(6, 0, 0);
        for (i = 0; i < 8; i = i + 1) wr(i[3:0] + 4'h2, $random(seed));
        for (i = 2; i < 12; i = i + 1) rd(i);
        repeat (60) pr(($random(seed) & 32'h7fffffff) % 7, $random(seed), $random(seed));
        for (i = 0; i < 12; i = i + 1) rd(i);
        test_done;
    end
endmodule // tb_cpu_register_set_and_flags
bind cpu_register_set reg_set_assertions chk (.clock, .rst, .aluOp, .aluSrc, .memData,
    .regWrite, .regRead, .regAddr, .stackPush, .fetchStep, .fetchLoad, .regRdata_ff,
    .workReg_ff, .flags_ff, .fetchPtr_ff, .stackPtr_ff);
